/* File: hdl/lsd_pkg.sv */
// constants, types and functions shared by the segment display controller
//
// Behaviour
// - display clock is 2048 Hz or 128 Hz
// - frame divider and clock select set waveform rate
// - sixteen divider settings, fewer at 128 Hz
// - active common steps at waveform rate
// - polarity inverts at twice waveform rate
// - blink enable in fixed or rate mode alternates shown and blanked screen, unless scrolling
// - software blink shows or blanks per mode field
// - automatic blink uses one of five rates
// - four screens, selected screen shown when unfrozen and not scrolling
// - auto scroll steps screens at twice blink rate
// - auto scroll works in every power mode
// - four banks of fifteen segment bytes
// - low nibble even segment, high nibble odd
// - byte n drives segments 2n and 2n+1 up to 28, segment 26 unused
// - segment memory kept during deep sleep
// - pointer write selects byte and starts access
// - freeze bit holds shown image during updates
// - pointer write with top bit stores data
// - pointer write with top bit clear loads data
// - pointer holds direction, screen and byte fields
// - clear bit and reset zero segment memory
`default_nettype none
package lsd_pkg;
   // ==========================================
   // register offsets
   localparam logic [7:0] LSD_ADDR_CONFIG = 8'h95;
   localparam logic [7:0] LSD_ADDR_CLOCK = 8'h96;
   localparam logic [7:0] LSD_ADDR_POINTER = 8'hAC;
   localparam logic [7:0] LSD_ADDR_DATA = 8'hAE;
   localparam logic [7:0] LSD_ADDR_SCREEN = 8'hB1;
   // ==========================================
   // field positions and reset values
   localparam int LSD_CFG_ENABLE_BIT = 7;
   localparam int LSD_CFG_CLEAR_BIT = 6;
   localparam int LSD_CFG_BLINK_BIT = 5;
   localparam int LSD_CFG_SLEEP_OFF_BIT = 4;
   localparam int LSD_CFG_DISPLAY_CLOCK_SELECT_BIT = 3;
   localparam int LSD_PTR_DIR_BIT = 7;
   localparam int LSD_PTR_RSVD_BIT = 6;
   localparam int LSD_SCR_AUTO_BIT = 7;
   localparam int LSD_SCR_FREEZE_BIT = 0;
   localparam logic [7:0] LSD_SCR_MASK = 8'h8D;
   localparam logic [7:0] LSD_REG_RESET = 8'h00;
   // ==========================================
   // memory geometry
   localparam int LSD_BANK_BYTES = 15;
   localparam logic [3:0] LSD_LAST_BYTE = 4'hE;
   localparam int LSD_MEM_WORDS = 60;
   localparam int LSD_SEG_PINS = 29;
   localparam int LSD_UNUSED_SEG = 26;
   // ==========================================
   // blink modes and access states
   typedef enum logic [1:0] {
      LSD_BLK_OFF = 2'b00,
      LSD_BLK_ON = 2'b01,
      LSD_BLK_FIXED = 2'b10,
      LSD_BLK_RATE = 2'b11
   } lsd_blink_mode_t;
   typedef enum logic [2:0] {
      LSD_ACC_IDLE = 3'b001,
      LSD_ACC_WAIT = 3'b010,
      LSD_ACC_LOAD = 3'b100
   } lsd_acc_state_t;
   // half blink periods in 128 Hz ticks: four rate codes, then the fixed rate
   localparam logic [8:0] LSD_BLINK_HALF [5] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010};
   // half waveform periods in ticks of the selected display clock
   localparam logic [7:0] LSD_HALF_2048_FD0 = 8'h10;
   localparam logic [7:0] LSD_HALF_2048_FD15 = 8'h08;
   localparam logic [7:0] LSD_HALF_128_FD0 = 8'h01;
   localparam logic [7:0] LSD_HALF_128_FD1 = 8'h02;
   localparam logic [7:0] LSD_HALF_128_FD2 = 8'h03;
   localparam logic [7:0] LSD_HALF_128_FD15 = 8'h01;
   localparam logic [7:0] LSD_HALF_128_OTHER = 8'h04;

   function automatic logic [7:0] lsd_wave_half(input logic slow, input logic [3:0] fd);
      logic [7:0] h;
      h = 8'h01;
      if (!slow) begin
         case (fd)
            4'h0: h = LSD_HALF_2048_FD0;
            4'hF: h = LSD_HALF_2048_FD15;
            default: h = {1'b0, fd + 4'h1, 3'b000};
         endcase
      end else begin
         case (fd)
            4'h0: h = LSD_HALF_128_FD0;
            4'h1: h = LSD_HALF_128_FD1;
            4'h2: h = LSD_HALF_128_FD2;
            4'hF: h = LSD_HALF_128_FD15;
            default: h = LSD_HALF_128_OTHER;
         endcase
      end
      return h;
   endfunction: lsd_wave_half

   function automatic logic [5:0] lsd_word_addr(input logic [1:0] screen, input logic [3:0] byte_addr);
      logic [5:0] s;
      s = {4'h0, screen};
      return 6'(s * 6'd15 + {2'b00, byte_addr});
   endfunction: lsd_word_addr
endpackage: lsd_pkg
`default_nettype wire

/* File: hdl/lsd_tick_div.sv */
// programmable divider of a slow tick stream, one pulse per div ticks
`timescale 1ns/10ps
`default_nettype none
module lsd_tick_div #(
   parameter int W = 9
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // tick stream and ratio
   input wire logic tick,
   input wire logic [W-1:0] div,
   // divided pulse
   output logic pulse
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic next_pulse;

   always_comb begin
      next_cnt = cnt;
      next_pulse = 1'b0;
      if (tick) begin
         if (cnt >= div - 1'b1) begin
            next_cnt = '0;
            next_pulse = 1'b1;
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cnt <= '0;
         pulse <= 1'b0;
      end else begin
         cnt <= next_cnt;
         pulse <= next_pulse;
      end
   end
endmodule: lsd_tick_div
`default_nettype wire

/* File: hdl/lsd_seg_mem.sv */
// segment memory, four screens of bytes, two registered read ports
`timescale 1ns/10ps
`default_nettype none
module lsd_seg_mem #(
   parameter int DEPTH = 60,
   parameter int AW = 6
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // clear and write
   input wire logic clear,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   // firmware read port
   input wire logic [AW-1:0] ra_addr,
   output logic [7:0] ra_data,
   // scan read port
   input wire logic [AW-1:0] rb_addr,
   output logic [7:0] rb_data
);
   logic [DEPTH-1:0][7:0] mem;
   logic [DEPTH-1:0][7:0] next_mem;
   logic [7:0] next_ra;
   logic [7:0] next_rb;

   // contents untouched by power modes, only clear or reset zero them
   always_comb begin
      next_mem = mem;
      if (clear) begin
         next_mem = '0;
      end else if (we && int'(waddr) < DEPTH) begin
         next_mem[waddr] = wdata;
      end
      next_ra = (int'(ra_addr) < DEPTH) ? mem[ra_addr] : 8'h00;
      next_rb = (int'(rb_addr) < DEPTH) ? mem[rb_addr] : 8'h00;
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         mem <= '0;
         ra_data <= 8'h00;
         rb_data <= 8'h00;
      end else begin
         mem <= next_mem;
         ra_data <= next_ra;
         rb_data <= next_rb;
      end
   end
endmodule: lsd_seg_mem
`default_nettype wire

/* File: hdl/lsd_display_ctrl.sv */
// segment display controller: registers, timing, blink, scroll, drive
`timescale 1ns/10ps
`default_nettype none
module lsd_display_ctrl (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // slow display time bases, one-cycle ticks
   input wire logic tick_2048,
   input wire logic tick_128,
   // power mode
   input wire logic deep_sleep_mode,
   // special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // glass drive
   output logic [3:0] backplane_line,
   output logic drive_invert,
   output logic [lsd_pkg::LSD_SEG_PINS-1:0] segment_pin,
   output logic display_active
);
   import lsd_pkg::*;

   // ==========================================
   // registers
   logic [7:0] display_config, display_clock_ctrl, segment_mem_pointer, segment_mem_data, screen_config;
   logic [7:0] next_config, next_clock, next_pointer, next_data, next_screen, next_rdata;
   lsd_acc_state_t acc_state, next_acc_state;
   logic clear_req, mem_we, ptr_ok;
   logic [5:0] mem_waddr;
   logic [7:0] mem_rdata_a, mem_rdata_b;
   logic [1:0] blink_mode_field, blink_rate_field, target_screen_field;
   logic [3:0] frame_divider;

   assign blink_mode_field = display_clock_ctrl[7:6];
   assign blink_rate_field = display_clock_ctrl[5:4];
   assign frame_divider = display_clock_ctrl[3:0];
   assign target_screen_field = segment_mem_pointer[5:4];
   assign ptr_ok = segment_mem_pointer[3:0] <= LSD_LAST_BYTE;

   always_comb begin
      next_config = display_config;
      next_clock = display_clock_ctrl;
      next_pointer = segment_mem_pointer;
      next_data = segment_mem_data;
      next_screen = screen_config;
      next_acc_state = acc_state;
      clear_req = 1'b0;
      mem_we = 1'b0;
      mem_waddr = lsd_word_addr(sfr_wdata[5:4], sfr_wdata[3:0]);
      case (acc_state)
         LSD_ACC_WAIT: next_acc_state = LSD_ACC_LOAD;
         LSD_ACC_LOAD: begin
            next_acc_state = LSD_ACC_IDLE;
            next_data = ptr_ok ? mem_rdata_a : 8'h00;
         end
         default: next_acc_state = LSD_ACC_IDLE;
      endcase
      if (sfr_wr) begin
         case (sfr_addr)
            LSD_ADDR_CONFIG: begin
               next_config = sfr_wdata;
               next_config[LSD_CFG_CLEAR_BIT] = 1'b0;
               clear_req = sfr_wdata[LSD_CFG_CLEAR_BIT];
            end
            LSD_ADDR_CLOCK: next_clock = sfr_wdata;
            LSD_ADDR_POINTER: begin
               next_pointer = sfr_wdata;
               next_pointer[LSD_PTR_RSVD_BIT] = 1'b0;
               if (sfr_wdata[LSD_PTR_DIR_BIT]) begin
                  mem_we = sfr_wdata[3:0] <= LSD_LAST_BYTE;
               end else begin
                  next_acc_state = LSD_ACC_WAIT;
               end
            end
            LSD_ADDR_DATA: begin
               if (acc_state != LSD_ACC_LOAD) begin
                  next_data = sfr_wdata;
               end
            end
            LSD_ADDR_SCREEN: next_screen = sfr_wdata & LSD_SCR_MASK;
            default: ;
         endcase
      end
      next_rdata = sfr_rdata;
      if (sfr_rd) begin
         case (sfr_addr)
            LSD_ADDR_CONFIG: next_rdata = display_config;
            LSD_ADDR_CLOCK: next_rdata = display_clock_ctrl;
            LSD_ADDR_POINTER: next_rdata = segment_mem_pointer;
            LSD_ADDR_DATA: next_rdata = segment_mem_data;
            LSD_ADDR_SCREEN: next_rdata = screen_config;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         display_config <= LSD_REG_RESET;
         display_clock_ctrl <= LSD_REG_RESET;
         segment_mem_pointer <= LSD_REG_RESET;
         segment_mem_data <= LSD_REG_RESET;
         screen_config <= LSD_REG_RESET;
         acc_state <= LSD_ACC_IDLE;
         sfr_rdata <= 8'h00;
      end else begin
         display_config <= next_config;
         display_clock_ctrl <= next_clock;
         segment_mem_pointer <= next_pointer;
         segment_mem_data <= next_data;
         screen_config <= next_screen;
         acc_state <= next_acc_state;
         sfr_rdata <= next_rdata;
      end
   end

   // ==========================================
   // segment memory and scan
   logic [3:0] scan_idx, scan_prev, next_scan_idx;
   logic [1:0] disp_screen, next_disp_screen;
   logic [LSD_BANK_BYTES-1:0][7:0] disp_latch, next_latch;
   logic freeze;

   assign freeze = screen_config[LSD_SCR_FREEZE_BIT];

   lsd_seg_mem #(.DEPTH(LSD_MEM_WORDS), .AW(6)) u_mem (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clear(clear_req),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(segment_mem_data),
      .ra_addr(lsd_word_addr(target_screen_field, segment_mem_pointer[3:0])),
      .ra_data(mem_rdata_a),
      .rb_addr(lsd_word_addr(disp_screen, scan_idx)),
      .rb_data(mem_rdata_b)
   );

   always_comb begin
      next_scan_idx = (scan_idx >= LSD_LAST_BYTE) ? 4'h0 : scan_idx + 4'h1;
      next_latch = disp_latch;
      if (!freeze) begin
         next_latch[scan_prev] = mem_rdata_b;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         scan_idx <= 4'h0;
         scan_prev <= 4'h0;
         disp_latch <= '0;
      end else begin
         scan_idx <= next_scan_idx;
         scan_prev <= scan_idx;
         disp_latch <= next_latch;
      end
   end

   // ==========================================
   // waveform timing
   logic tick_src, half_pulse, invert, next_invert;
   logic [1:0] com_idx, next_com_idx, mux_level;

   assign tick_src = display_config[LSD_CFG_DISPLAY_CLOCK_SELECT_BIT] ? tick_128 : tick_2048;
   assign mux_level = display_config[1:0];

   lsd_tick_div #(.W(8)) u_wave (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .tick(tick_src),
      .div(lsd_wave_half(display_config[LSD_CFG_DISPLAY_CLOCK_SELECT_BIT], frame_divider)),
      .pulse(half_pulse)
   );

   always_comb begin
      next_invert = invert;
      next_com_idx = com_idx;
      if (half_pulse) begin
         next_invert = ~invert;
         if (invert) begin
            next_com_idx = (com_idx >= mux_level) ? 2'b00 : com_idx + 2'b01;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         invert <= 1'b0;
         com_idx <= 2'b00;
      end else begin
         invert <= next_invert;
         com_idx <= next_com_idx;
      end
   end

   // ==========================================
   // blink and scroll
   logic blink_pulse, blink_phase, next_blink_phase, scroll_on, show, next_show, blink_en;
   logic [1:0] scroll_screen, next_scroll_screen;

   assign blink_en = display_config[LSD_CFG_BLINK_BIT];
   assign scroll_on = screen_config[LSD_SCR_AUTO_BIT] && blink_en && blink_mode_field == LSD_BLK_RATE;

   lsd_tick_div #(.W(9)) u_blink (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .tick(tick_128),
      .div(blink_mode_field == LSD_BLK_RATE ? LSD_BLINK_HALF[blink_rate_field] : LSD_BLINK_HALF[4]),
      .pulse(blink_pulse)
   );

   // scroll ignores deep_sleep_mode so it keeps running in every power mode
   always_comb begin
      next_blink_phase = blink_pulse ? ~blink_phase : blink_phase;
      next_scroll_screen = scroll_screen;
      if (scroll_on && blink_pulse) begin
         next_scroll_screen = scroll_screen + 2'b01;
      end
      next_disp_screen = disp_screen;
      if (!freeze) begin
         next_disp_screen = scroll_on ? scroll_screen : screen_config[3:2];
      end
      next_show = display_config[LSD_CFG_ENABLE_BIT] && !(deep_sleep_mode && display_config[LSD_CFG_SLEEP_OFF_BIT]);
      if (blink_en && !scroll_on) begin
         case (blink_mode_field)
            LSD_BLK_OFF: next_show = 1'b0;
            LSD_BLK_ON: next_show = next_show;
            default: next_show = next_show && blink_phase;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         blink_phase <= 1'b1;
         scroll_screen <= 2'b00;
         disp_screen <= 2'b00;
         show <= 1'b0;
      end else begin
         blink_phase <= next_blink_phase;
         scroll_screen <= next_scroll_screen;
         disp_screen <= next_disp_screen;
         show <= next_show;
      end
   end

   // ==========================================
   // glass drive outputs
   logic [LSD_SEG_PINS-1:0] next_seg;
   logic [3:0] next_bp;

   always_comb begin
      next_bp = show ? (4'h1 << com_idx) : 4'h0;
      for (int k = 0; k < LSD_SEG_PINS; k++) begin
         next_seg[k] = invert ^ (show && disp_latch[k / 2][(k % 2) * 4 + int'(com_idx)]);
      end
      next_seg[LSD_UNUSED_SEG] = invert;
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         segment_pin <= '0;
         backplane_line <= 4'h0;
         drive_invert <= 1'b0;
         display_active <= 1'b0;
      end else begin
         segment_pin <= next_seg;
         backplane_line <= next_bp;
         drive_invert <= invert;
         display_active <= show;
      end
   end

   // ==========================================
   // assertions
   property p_ptr_write;
      @(posedge sys_clk) disable iff (!resetn)
      (sfr_wr && sfr_addr == LSD_ADDR_POINTER && sfr_wdata[LSD_PTR_DIR_BIT] && sfr_wdata[3:0] <= LSD_LAST_BYTE)
      |-> mem_we && mem_waddr == 6'(int'(sfr_wdata[5:4]) * LSD_BANK_BYTES + int'(sfr_wdata[3:0]));
   endproperty
   a_ptr_write: assert property (p_ptr_write) else $error("pointer write did not store data");
   property p_ptr_read;
      @(posedge sys_clk) disable iff (!resetn)
      (sfr_wr && sfr_addr == LSD_ADDR_POINTER && !sfr_wdata[LSD_PTR_DIR_BIT]) |=> ##1 acc_state == LSD_ACC_LOAD;
   endproperty
   a_ptr_read: assert property (p_ptr_read) else $error("pointer read did not reach load");
   property p_read_load;
      @(posedge sys_clk) disable iff (!resetn)
      (acc_state == LSD_ACC_LOAD && ptr_ok) |=> segment_mem_data == $past(mem_rdata_a);
   endproperty
   a_read_load: assert property (p_read_load) else $error("data register not loaded from memory");
   property p_clear;
      @(posedge sys_clk) disable iff (!resetn)
      (clear_req ##1 !mem_we) |=> mem_rdata_b == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("memory not cleared");
   property p_freeze;
      @(posedge sys_clk) disable iff (!resetn)
      freeze |=> $stable(disp_latch) && $stable(disp_screen);
   endproperty
   a_freeze: assert property (p_freeze) else $error("image changed while frozen");
   property p_invert;
      @(posedge sys_clk) disable iff (!resetn)
      half_pulse |=> invert != $past(invert) ##1 drive_invert == $past(invert);
   endproperty
   a_invert: assert property (p_invert) else $error("polarity did not invert");
   property p_com_step;
      @(posedge sys_clk) disable iff (!resetn)
      (half_pulse && invert && com_idx >= mux_level) |=> com_idx == 2'b00;
   endproperty
   a_com_step: assert property (p_com_step) else $error("common did not wrap");
   property p_soft_blank;
      @(posedge sys_clk) disable iff (!resetn)
      (blink_en && !scroll_on && blink_mode_field == LSD_BLK_OFF) |=> !show ##1 !display_active;
   endproperty
   a_soft_blank: assert property (p_soft_blank) else $error("display not blanked");
   property p_scroll;
      @(posedge sys_clk) disable iff (!resetn)
      (scroll_on && blink_pulse) |=> scroll_screen == $past(scroll_screen) + 2'b01;
   endproperty
   a_scroll: assert property (p_scroll) else $error("scroll did not advance");
   property p_unused_seg;
      @(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> segment_pin[LSD_UNUSED_SEG] == drive_invert;
   endproperty
   a_unused_seg: assert property (p_unused_seg) else $error("unused segment driven");
   c_write: cover property (@(posedge sys_clk) disable iff (!resetn) mem_we);
   c_read: cover property (@(posedge sys_clk) disable iff (!resetn) acc_state == LSD_ACC_LOAD);
   c_scroll: cover property (@(posedge sys_clk) disable iff (!resetn) scroll_on && blink_pulse);
   c_freeze: cover property (@(posedge sys_clk) disable iff (!resetn) freeze && show);
endmodule: lsd_display_ctrl
`default_nettype wire

/* File: verification/lsd_glass_model.sv */
// passive glass model: recovers lit segments from the drive lines
`timescale 1ns/10ps
`default_nettype none
module lsd_glass_model (
   // drive from the controller
   input wire logic [3:0] backplane_line,
   input wire logic drive_invert,
   input wire logic [lsd_pkg::LSD_SEG_PINS-1:0] segment_pin,
   // lit segments on the active common
   output logic [lsd_pkg::LSD_SEG_PINS-1:0] seg_on,
   output logic com_live
);
   import lsd_pkg::*;
   assign seg_on = segment_pin ^ {LSD_SEG_PINS{drive_invert}};
   assign com_live = |backplane_line;
endmodule: lsd_glass_model
`default_nettype wire

/* File: verification/lsd_display_ctrl_test.sv */
// self-checking bench for the segment display controller
`timescale 1ns/10ps
`default_nettype none
module lsd_display_ctrl_test;
   import lsd_pkg::*;
   logic sys_clk = 1'b0, resetn = 1'b0, tick_2048 = 1'b0, tick_128 = 1'b0, deep_sleep_mode = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic sfr_wr = 1'b0, sfr_rd = 1'b0, drive_invert, display_active, com_live;
   logic [3:0] backplane_line;
   logic [LSD_SEG_PINS-1:0] segment_pin, seg_on;
   logic [31:0] seed = 32'h8F24EF62;
   logic [7:0] regs [6] = '{LSD_ADDR_CONFIG, LSD_ADDR_CLOCK, LSD_ADDR_POINTER, LSD_ADDR_DATA, LSD_ADDR_SCREEN, 8'h40};
   int fails = 0, checked = 0, cyc = 0;
   always #5 sys_clk = ~sys_clk;
   // fast time bases: 2048 tick every 8 cycles, 128 tick every 128
   always @(negedge sys_clk) begin
      cyc <= cyc + 1;
      tick_2048 <= (cyc % 8) == 0;
      tick_128 <= (cyc % 128) == 0;
   end
   lsd_display_ctrl u_dut (.sys_clk, .resetn, .tick_2048, .tick_128, .deep_sleep_mode, .sfr_addr, .sfr_wdata,
      .sfr_wr, .sfr_rd, .sfr_rdata, .backplane_line, .drive_invert, .segment_pin, .display_active);
   lsd_glass_model u_glass (.backplane_line, .drive_invert, .segment_pin, .seg_on, .com_live);
   // ==========================================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction: xs
   function automatic int exp_half(input logic slow, input logic [3:0] fd);
      if (slow) return 128 * ((fd == 4'h0 || fd == 4'hF) ? 1 : (fd < 4'h3) ? int'(fd) + 1 : 4);
      return 8 * ((fd == 4'h0) ? 16 : (fd == 4'hF) ? 8 : 8 * (int'(fd) + 1));
   endfunction: exp_half
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask: check
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask: close_out
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
      @(negedge sys_clk);
   endtask: wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge sys_clk);
      sfr_rd = 1'b0;
      @(negedge sys_clk);
      d = sfr_rdata;
   endtask: rd
   task automatic mem_wr(input logic [1:0] s, input logic [3:0] a, input logic [7:0] d);
      wr(LSD_ADDR_DATA, d);
      wr(LSD_ADDR_POINTER, {2'b10, s, a});
   endtask: mem_wr
   task automatic mem_rd(input logic [1:0] s, input logic [3:0] a, output logic [7:0] d);
      wr(LSD_ADDR_POINTER, {2'b00, s, a});
      repeat (2) @(negedge sys_clk);
      rd(LSD_ADDR_DATA, d);
   endtask: mem_rd
   task automatic wait_com(input int c);
      for (int n = 0; n < 3000 && backplane_line !== (4'h1 << c); n++) @(negedge sys_clk);
      check("common reached", backplane_line, 4'h1 << c);
   endtask: wait_com
   task automatic see(input logic [3:0] a, input logic [7:0] d);
      for (int c = 0; c < 4; c++) begin
         wait_com(c);
         check("segment pair", {seg_on[2*a+1], seg_on[2*a]}, {d[4+c], d[c]});
      end
   endtask: see
   task automatic flip(input bit blk, output int n);
      logic p;
      for (int k = 0; k < 3; k++) begin
         p = blk ? display_active : drive_invert;
         for (n = 0; n < 9000 && (blk ? display_active : drive_invert) === p; n++) @(negedge sys_clk);
      end
   endtask: flip
   // ==========================================
   // main sequence
   initial begin
      logic [7:0] d, v, r;
      logic [3:0] a;
      logic [1:0] id, prev;
      int n, steps;
      repeat (20) @(negedge sys_clk);
      resetn = 1'b1;
      @(negedge sys_clk);
      wr(8'h40, 8'hFF);
      foreach (regs[i]) begin
         rd(regs[i], r);
         check("reset or unmapped", r, 8'h00);
      end
      $display("test registers done");
      for (int k = 0; k < 8; k++) begin
         seed = xs(seed);
         a = seed[3:0] % 4'hF;
         mem_wr(seed[5:4], a, seed[15:8]);
         mem_rd(seed[5:4], a, r);
         check("memory byte", r, seed[15:8]);
      end
      mem_wr(2'd3, LSD_LAST_BYTE, 8'hA5);
      mem_rd(2'd3, LSD_LAST_BYTE, r);
      check("last byte", r, 8'hA5);
      mem_rd(2'd3, 4'hF, r);
      check("byte past end", r, 8'h00);
      wr(LSD_ADDR_POINTER, 8'h7F);
      rd(LSD_ADDR_POINTER, r);
      check("pointer fields", r, 8'h3F);
      wr(LSD_ADDR_CONFIG, 8'h40);
      mem_rd(2'd3, LSD_LAST_BYTE, r);
      check("cleared byte", r, 8'h00);
      rd(LSD_ADDR_CONFIG, r);
      check("clear self-clears", r, 8'h00);
      $display("test memory done");
      seed = xs(seed);
      a = seed[3:0] % 4'hD;
      d = seed[15:8];
      v = seed[23:16];
      wr(LSD_ADDR_CONFIG, 8'h83);
      wr(LSD_ADDR_CLOCK, 8'h00);
      mem_wr(2'd0, a, d);
      repeat (40) @(negedge sys_clk);
      check("shown", display_active, 1'b1);
      see(a, d);
      wr(LSD_ADDR_SCREEN, 8'h01);
      mem_wr(2'd0, a, ~d);
      repeat (40) @(negedge sys_clk);
      see(a, d);
      wr(LSD_ADDR_SCREEN, 8'h00);
      repeat (40) @(negedge sys_clk);
      see(a, ~d);
      mem_wr(2'd1, a, v);
      wr(LSD_ADDR_SCREEN, 8'h04);
      repeat (40) @(negedge sys_clk);
      see(a, v);
      $display("test image done");
      foreach (regs[i]) if (i < 3) begin
         wr(LSD_ADDR_CONFIG, i == 2 ? 8'h8A : 8'h81);
         wr(LSD_ADDR_CLOCK, {4'h0, 4'(i * 5)});
         flip(1'b0, n);
         check("half period", n, exp_half(i == 2, 4'(i * 5)));
      end
      $display("test waveform done");
      wr(LSD_ADDR_CONFIG, 8'hA3);
      wr(LSD_ADDR_CLOCK, 8'h00);
      repeat (4) @(negedge sys_clk);
      check("software blank", display_active, 1'b0);
      wr(LSD_ADDR_CLOCK, 8'h40);
      repeat (4) @(negedge sys_clk);
      check("software show", display_active, 1'b1);
      wr(LSD_ADDR_CLOCK, 8'h80);
      flip(1'b1, n);
      check("blink half", n, 16 * 128);
      $display("test blink done");
      for (int k = 0; k < 4; k++) mem_wr(2'(k), a, {3'b000, k[1], 3'b000, k[0]});
      deep_sleep_mode = 1'b1;
      wr(LSD_ADDR_SCREEN, 8'h80);
      wr(LSD_ADDR_CLOCK, 8'hF0);
      prev = 2'd0;
      steps = 0;
      for (int k = 0; k < 24; k++) begin
         wait_com(1);
         wait_com(0);
         id = {seg_on[2*a+1], seg_on[2*a]};
         check("shown in scroll", display_active, 1'b1);
         if (id !== prev) begin
            check("scroll step", id, 2'(prev + 2'd1));
            steps++;
         end
         prev = id;
      end
      check("scroll in sleep", steps > 2, 1'b1);
      wr(LSD_ADDR_CONFIG, 8'h93);
      repeat (4) @(negedge sys_clk);
      check("off in sleep", display_active, 1'b0);
      check("commons idle", com_live, 1'b0);
      mem_rd(2'd2, a, r);
      check("kept in sleep", r, 8'h10);
      $display("test scroll done");
      close_out();
   end
   initial begin
      repeat (90000) @(posedge sys_clk);
      fails++;
      close_out();
   end
endmodule: lsd_display_ctrl_test
`default_nettype wire
